// ==== pkg/ipst_pkg.sv ====
/*
 * Package of the interrupt pending-state block: register offsets,
 * field positions, reset values and state encodings.
 * Assumes a 32-bit Avalon-MM slave with word addressing in bytes.
 */
package ipst_pkg;
    // ========================================================
    // Geometry
    localparam int IPST_NUM_IRQ = 32;
    localparam int IPST_ID_W = 9;
    localparam int IPST_PRIO_W = 4;
    localparam int IPST_ADDR_W = 8;
    // ========================================================
    // Register byte offsets
    localparam logic [7:0] IPST_OFS_SET_PEND = 8'h00;
    localparam logic [7:0] IPST_OFS_CLR_PEND = 8'h04;
    localparam logic [7:0] IPST_OFS_ACTIVE = 8'h08;
    localparam logic [7:0] IPST_OFS_ENABLE = 8'h0C;
    localparam logic [7:0] IPST_OFS_SYS_CTRL = 8'h10;
    localparam logic [7:0] IPST_OFS_SW_TRIG = 8'h14;
    localparam logic [7:0] IPST_OFS_LEVEL_SEL = 8'h18;
    localparam logic [7:0] IPST_OFS_PRIO_BASE = 8'h20;
    localparam logic [7:0] IPST_OFS_PRIO_LAST = 8'h3C;
    // ========================================================
    // Fields
    localparam int IPST_PERMIT_BIT = 1;
    localparam int IPST_PRIO_LSB = 4;
    // ========================================================
    // Reset values
    localparam logic [31:0] IPST_RST_WORD = 32'h0000_0000;
    localparam logic [31:0] IPST_UNMAPPED_RD = 32'h0000_0000;
    // ========================================================
    // Bus answer state
    typedef enum logic [1:0] {
        IPST_BUS_IDLE = 2'b01,
        IPST_BUS_DONE = 2'b10
    } ipst_bus_t;
endpackage

// ==== hdl/ipst_core.sv ====
/*
 * Interrupt pending/active state block with software trigger register.
 * Holds per-line pending and active flags, latches level or rising-edge
 * requests, and serves the registers over Avalon-MM with waitrequest.
 * Assumes request lines are asynchronous to clk and the core gives
 * one-cycle entry and return pulses carrying the interrupt number.
 */
// Summary of operation
// - Trigger register write makes the named interrupt pending.
// - Trigger ID field is a plain binary interrupt number.
// - Unprivileged trigger writes need the user permit bit set.
// - User permit bit writable only by privileged accesses.
// - Level-selected request line high while not active sets pending.
// - Rising edge on request line sets pending, even short pulses.
// - Set-pending bit or trigger register write sets pending.
// - Handler entry clears pending and sets active.
// - Level return: line still high gives pending, else inactive.
// - No pulse during handler: return leaves the interrupt inactive.
// - Level clear-pending ignored while line high, else clears.
// - Pending is set regardless of the enable bit.
// - Clear-pending leaves active alone; writing zeros does nothing.
// - Set-pending on pending or disabled interrupt just pends.
// - Active flag reads one when active or active and pending.
// - Four-bit priority in the byte's upper bits, lower bits zero.
`timescale 1ns/1ps
module ipst_core
    import ipst_pkg::*;
#(
    parameter int NUM_IRQ = ipst_pkg::IPST_NUM_IRQ
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [ipst_pkg::IPST_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_privileged,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Peripheral request lines
    input wire logic [NUM_IRQ-1:0] irq_line,
    // Processor core handshake
    input wire logic core_entry,
    input wire logic [ipst_pkg::IPST_ID_W-1:0] core_entry_id,
    input wire logic core_return,
    input wire logic [ipst_pkg::IPST_ID_W-1:0] core_return_id,
    // State outputs
    output logic [NUM_IRQ-1:0] irq_pending,
    output logic [NUM_IRQ-1:0] irq_active,
    output logic [NUM_IRQ-1:0] irq_take
);
    import ipst_pkg::*;

    // ========================================================
    // State
    typedef struct packed {
        logic [NUM_IRQ-1:0] sync1;
        logic [NUM_IRQ-1:0] sync2;
        logic [NUM_IRQ-1:0] sync3;
        logic [NUM_IRQ-1:0] pend;
        logic [NUM_IRQ-1:0] act;
        logic [NUM_IRQ-1:0] ena;
        logic [NUM_IRQ-1:0] level_sel;
        logic [NUM_IRQ-1:0] take;
        logic [NUM_IRQ*IPST_PRIO_W-1:0] prio;
        logic user_permit;
        ipst_bus_t bus;
        logic [31:0] rdata;
        logic waitreq;
    } ipst_state_t;

    ipst_state_t st_q;
    ipst_state_t st_d;

    // One-hot mask for an interrupt number, zero when out of range
    function automatic logic [NUM_IRQ-1:0] ipst_onehot(input logic [IPST_ID_W-1:0] id);
        logic [NUM_IRQ-1:0] m;
        m = '0;
        if (int'(id) < NUM_IRQ)
        begin
            m[int'(id)] = 1'b1;
        end
        return m;
    endfunction

    // Pack the priority nibble into the upper half of its byte
    function automatic logic [7:0] ipst_prio_byte(input logic [IPST_PRIO_W-1:0] p);
        return {p, 4'h0};
    endfunction

    // ========================================================
    // Next-state logic
    always_comb
    begin
        logic [NUM_IRQ-1:0] stable;
        logic [NUM_IRQ-1:0] set_mask;
        logic [NUM_IRQ-1:0] clr_mask;
        logic [NUM_IRQ-1:0] ent_mask;
        logic [NUM_IRQ-1:0] ret_mask;
        logic [NUM_IRQ-1:0] wmask;
        logic [31:0] rd;
        logic wr_go;
        logic rd_go;
        int idx;
        stable = '0;
        set_mask = '0;
        clr_mask = '0;
        ent_mask = '0;
        ret_mask = '0;
        wmask = '0;
        rd = IPST_UNMAPPED_RD;
        wr_go = 1'b0;
        rd_go = 1'b0;
        idx = 0;
        st_d = st_q;

        // Three-stage synchroniser; level counts once stages 2 and 3 agree
        st_d.sync1 = irq_line;
        st_d.sync2 = st_q.sync1;
        st_d.sync3 = st_q.sync2;
        // Only the second stage reads the first; the first may be metastable
        stable = st_q.sync2 & st_q.sync3;
        // Rising edges are taken where stage 2 is high and stage 3 low, so that a pulse one
        // clock long still latches; see the edge term further down

        // Bus handshake: one wait cycle, answer on the second edge
        wr_go = avs_write && (st_q.bus == IPST_BUS_IDLE);
        rd_go = avs_read && (st_q.bus == IPST_BUS_IDLE);
        wmask = avs_writedata[NUM_IRQ-1:0];
        // Waitrequest is registered high and drops for the answer cycle only
        case (st_q.bus)
            IPST_BUS_DONE:
            begin
                // Answer stood one cycle, back to waiting
                st_d.bus = IPST_BUS_IDLE;
                st_d.waitreq = 1'b1;
            end
            IPST_BUS_IDLE:
            begin
                if (wr_go || rd_go)
                begin
                    st_d.bus = IPST_BUS_DONE;
                    st_d.waitreq = 1'b0;
                end
            end
            default:
            begin
                st_d.bus = IPST_BUS_IDLE;
                st_d.waitreq = 1'b1;
            end
        endcase

        // Register writes
        if (wr_go)
        begin
            if (avs_address == IPST_OFS_SET_PEND)
            begin
                set_mask = wmask;
            end
            else if (avs_address == IPST_OFS_CLR_PEND)
            begin
                clr_mask = wmask & ~(st_q.level_sel & stable);
            end
            else if (avs_address == IPST_OFS_ENABLE)
            begin
                st_d.ena = wmask;
            end
            else if (avs_address == IPST_OFS_SYS_CTRL)
            begin
                if (avs_privileged)
                begin
                    st_d.user_permit = avs_writedata[IPST_PERMIT_BIT];
                end
            end
            else if (avs_address == IPST_OFS_SW_TRIG)
            begin
                if (avs_privileged || st_q.user_permit)
                begin
                    set_mask = ipst_onehot(avs_writedata[IPST_ID_W-1:0]);
                end
            end
            else if (avs_address == IPST_OFS_LEVEL_SEL)
            begin
                st_d.level_sel = wmask;
            end
            else if (avs_address >= IPST_OFS_PRIO_BASE && avs_address <= IPST_OFS_PRIO_LAST)
            begin
                for (int b = 0; b < 4; b++)
                begin
                    idx = int'(avs_address - IPST_OFS_PRIO_BASE) + b;
                    if (avs_byteenable[b] && idx < NUM_IRQ)
                    begin
                        st_d.prio[idx*IPST_PRIO_W +: IPST_PRIO_W] =
                            avs_writedata[b*8+IPST_PRIO_LSB +: IPST_PRIO_W];
                    end
                end
            end
        end

        // Register reads
        if (rd_go)
        begin
            if (avs_address == IPST_OFS_SET_PEND || avs_address == IPST_OFS_CLR_PEND)
            begin
                rd = 32'(st_q.pend);
            end
            else if (avs_address == IPST_OFS_ACTIVE)
            begin
                rd = 32'(st_q.act);
            end
            else if (avs_address == IPST_OFS_ENABLE)
            begin
                rd = 32'(st_q.ena);
            end
            else if (avs_address == IPST_OFS_SYS_CTRL)
            begin
                rd[IPST_PERMIT_BIT] = st_q.user_permit;
            end
            else if (avs_address == IPST_OFS_LEVEL_SEL)
            begin
                rd = 32'(st_q.level_sel);
            end
            else if (avs_address >= IPST_OFS_PRIO_BASE && avs_address <= IPST_OFS_PRIO_LAST)
            begin
                for (int b = 0; b < 4; b++)
                begin
                    idx = int'(avs_address - IPST_OFS_PRIO_BASE) + b;
                    if (idx < NUM_IRQ)
                    begin
                        rd[b*8 +: 8] =
                            ipst_prio_byte(st_q.prio[idx*IPST_PRIO_W +: IPST_PRIO_W]);
                    end
                end
            end
            st_d.rdata = rd;
        end

        // Handler entry and return masks from the core
        ent_mask = core_entry ? ipst_onehot(core_entry_id) : '0;
        ret_mask = core_return ? ipst_onehot(core_return_id) : '0;

        // level high and not active; an entry this cycle counts as active
        // so a held level line does not re-pend the interrupt being entered
        set_mask = set_mask | (st_q.level_sel & stable & ~(st_q.act | ent_mask));
        set_mask = set_mask | (~st_q.level_sel & st_q.sync2 & ~st_q.sync3);
        set_mask = set_mask | (ret_mask & st_q.level_sel & stable);

        // set on pending is idempotent; set wins, gives act+pend
        st_d.pend = ((st_q.pend & ~clr_mask) & ~ent_mask) | set_mask;
        // return with no new event ends inactive
        st_d.act = (st_q.act | ent_mask) & ~ret_mask;

        // Candidates for the core: enabled and pending
        st_d.take = st_d.pend & st_d.ena;
    end

    // ========================================================
    // State register
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            st_q <= '{sync1: '0, sync2: '0, sync3: '0, pend: '0, act: '0,
                      ena: '0, level_sel: '0, take: '0, prio: '0,
                      user_permit: 1'b0, bus: IPST_BUS_IDLE,
                      rdata: IPST_RST_WORD, waitreq: 1'b1};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ========================================================
    // Outputs straight from flip-flops
    assign avs_readdata = st_q.rdata;
    assign avs_waitrequest = st_q.waitreq;
    assign irq_pending = st_q.pend;
    assign irq_active = st_q.act;
    assign irq_take = st_q.take;
endmodule

// ==== test/ipst_core_sva.sv ====
/* Port checker of the pending-state block.
   Bound into ipst_core; sees only its ports. */
`timescale 1ns/1ps
module ipst_core_sva
    import ipst_pkg::*;
#(
    parameter int NUM_IRQ = 32
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Bus
    input wire logic [ipst_pkg::IPST_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_privileged,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Lines and core
    input wire logic [NUM_IRQ-1:0] irq_line,
    input wire logic core_entry,
    input wire logic [ipst_pkg::IPST_ID_W-1:0] core_entry_id,
    input wire logic core_return,
    input wire logic [ipst_pkg::IPST_ID_W-1:0] core_return_id,
    // State
    input wire logic [NUM_IRQ-1:0] irq_pending,
    input wire logic [NUM_IRQ-1:0] irq_active,
    input wire logic [NUM_IRQ-1:0] irq_take
);
    import ipst_pkg::*;
    // ==========================================
    // Helpers
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Write taken at this edge
    wire wr_take = avs_write && avs_waitrequest;
    // ==========================================
    // Assertions
    chk_bus_answer: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
        else $error("bus request not answered");
    chk_answer_once: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer stood too long");
    chk_trig_pend: assert property (wr_take && avs_privileged && avs_address == IPST_OFS_SW_TRIG
        && avs_writedata[8:0] < 9'(NUM_IRQ) |=> irq_pending[$past(avs_writedata[4:0])])
        else $error("trigger did not pend");
    chk_set_pend: assert property (wr_take && avs_address == IPST_OFS_SET_PEND
        |=> (irq_pending & $past(avs_writedata)) == $past(avs_writedata))
        else $error("set bits did not pend");
    chk_clr_zero: assert property (wr_take && avs_address == IPST_OFS_CLR_PEND
        && avs_writedata == 0 && !core_entry |=> ($past(irq_pending) & ~irq_pending) == '0)
        else $error("zero clear changed pending");
    chk_entry_act: assert property (core_entry && core_entry_id < 9'(NUM_IRQ)
        |=> irq_active[$past(core_entry_id[4:0])])
        else $error("entry did not set active");
    chk_return_off: assert property (core_return && !core_entry && core_return_id < 9'(NUM_IRQ)
        |=> !irq_active[$past(core_return_id[4:0])])
        else $error("return left active");
    chk_take_pend: assert property ((irq_take & ~irq_pending) == '0)
        else $error("take without pending");
    // Main scenarios
    cov_entry: cover property (core_entry);
    cov_trig: cover property (wr_take && avs_address == IPST_OFS_SW_TRIG);
    cov_act_pend: cover property ((irq_pending & irq_active) != '0);
endmodule

bind ipst_core ipst_core_sva #(.NUM_IRQ(NUM_IRQ)) u_sva (.*);

// ==== test/ipst_far.sv ====
/* Far side model: peripheral request lines and core handshake.
   Driven by bench task calls; changes just after rising edges. */
`timescale 1ns/1ps
module ipst_far #(
    parameter int NUM_IRQ = 32
)
(
    // Clock
    input wire logic clk,
    // Peripheral lines
    output logic [NUM_IRQ-1:0] irq_line,
    // Core handshake
    output logic core_entry,
    output logic [8:0] core_entry_id,
    output logic core_return,
    output logic [8:0] core_return_id
);
    // Quiet at start
    initial
    begin
        irq_line = '0;
        {core_entry, core_return, core_entry_id, core_return_id} = '0;
    end
    task automatic line(input int n, input logic v);
        @(posedge clk);
        irq_line[n] <= v;
    endtask
    task automatic pulse(input int n);
        line(n, 1'b1);
        line(n, 1'b0);
    endtask
    // Handler entry pulse
    task automatic enter(input int n);
        @(posedge clk);
        core_entry <= 1'b1;
        core_entry_id <= 9'(n);
        @(posedge clk);
        core_entry <= 1'b0;
        core_entry_id <= ~9'(n);
    endtask
    // Handler return pulse
    task automatic leave(input int n);
        @(posedge clk);
        core_return <= 1'b1;
        core_return_id <= 9'(n);
        @(posedge clk);
        core_return <= 1'b0;
        core_return_id <= ~9'(n);
    endtask
endmodule

// ==== test/test_irq_pending_state_and_soft_trigger.sv ====
/* Bench of the pending-state block over Avalon-MM.
   Assumes ipst_core, ipst_far and the bound checker. */
`timescale 1ns/1ps
module test_irq_pending_state_and_soft_trigger;
    import ipst_pkg::*;
    logic clk = 0, rst_b = 0, avs_read = 0, avs_write = 0, avs_privileged = 0;
    logic [7:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata;
    logic [3:0] avs_byteenable = 4'hF;
    logic avs_waitrequest, core_entry, core_return;
    logic [8:0] core_entry_id, core_return_id;
    logic [31:0] irq_line, irq_pending, irq_active, irq_take;
    int n_errors = 0, checked = 0;
    // Clock
    always #12.5 clk = ~clk;
    ipst_far far (.clk(clk), .irq_line(irq_line), .core_entry(core_entry),
        .core_entry_id(core_entry_id), .core_return(core_return), .core_return_id(core_return_id));
    ipst_core dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_privileged(avs_privileged), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq_line(irq_line), .core_entry(core_entry),
        .core_entry_id(core_entry_id), .core_return(core_return),
        .core_return_id(core_return_id), .irq_pending(irq_pending), .irq_active(irq_active),
        .irq_take(irq_take));
    // One bus cycle, held until waitrequest is seen low
    // aligned words; byte lanes from avs_byteenable, set by the caller
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic p, output logic [31:0] q);
        @(posedge clk);
        {avs_address, avs_read, avs_write, avs_writedata, avs_privileged} <= {a, !w, w, d, p};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        {avs_read, avs_write} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic p = 1'b1);
        logic [31:0] q;
        bus(1'b1, a, d, p, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, 1'b1, q);
        checked++;
        if (q !== e)
        begin
            n_errors++;
            $display("unexpected reg %h: expected %h seen %h", a, e, q);
        end
    endtask
    // Compare the take output, settled since the last bus answer
    task automatic see(input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            n_errors++;
            $display("unexpected irq_take: expected %h seen %h", e, s);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        conclude();
    end
    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(IPST_OFS_ACTIVE, 32'h0000_0000);
        wr(IPST_OFS_SW_TRIG, 32'h0000_0003);
        wr(IPST_OFS_SET_PEND, 32'h0000_0008);
        rd(IPST_OFS_SET_PEND, 32'h0000_0008);
        wr(IPST_OFS_SW_TRIG, 32'h0000_0028);
        wr(IPST_OFS_SW_TRIG, 32'h0000_00EF);
        wr(IPST_OFS_SW_TRIG, 32'h0000_0005, 1'b0);
        wr(IPST_OFS_SYS_CTRL, 32'h0000_0002, 1'b0);
        rd(IPST_OFS_SYS_CTRL, 32'h0000_0000);
        rd(IPST_OFS_SET_PEND, 32'h0000_0008);
        wr(IPST_OFS_SYS_CTRL, 32'h0000_0002);
        rd(IPST_OFS_SYS_CTRL, 32'h0000_0002);
        wr(IPST_OFS_SW_TRIG, 32'h0000_0005, 1'b0);
        wr(IPST_OFS_CLR_PEND, 32'h0000_0000);
        rd(IPST_OFS_CLR_PEND, 32'h0000_0028);
        wr(IPST_OFS_CLR_PEND, 32'h0000_0028);
        rd(IPST_OFS_SET_PEND, 32'h0000_0000);
        // Software pend, entry, retrigger in handler
        wr(IPST_OFS_SET_PEND, 32'h0000_0080);
        far.enter(7);
        rd(IPST_OFS_SET_PEND, 32'h0000_0000);
        wr(IPST_OFS_SW_TRIG, 32'h0000_0007);
        rd(IPST_OFS_SET_PEND, 32'h0000_0080);
        wr(IPST_OFS_CLR_PEND, 32'h0000_0080);
        rd(IPST_OFS_ACTIVE, 32'h0000_0080);
        far.leave(7);
        rd(IPST_OFS_ACTIVE, 32'h0000_0000);
        // Edge line, short pulse
        far.pulse(4);
        repeat (6) @(posedge clk);
        rd(IPST_OFS_SET_PEND, 32'h0000_0010);
        far.enter(4);
        far.leave(4);
        rd(IPST_OFS_SET_PEND, 32'h0000_0000);
        // Level line held through handler
        wr(IPST_OFS_LEVEL_SEL, 32'h0000_0004);
        rd(IPST_OFS_LEVEL_SEL, 32'h0000_0004);
        far.line(2, 1'b1);
        repeat (6) @(posedge clk);
        rd(IPST_OFS_SET_PEND, 32'h0000_0004);
        far.enter(2);
        rd(IPST_OFS_ACTIVE, 32'h0000_0004);
        rd(IPST_OFS_SET_PEND, 32'h0000_0000);
        far.leave(2);
        rd(IPST_OFS_SET_PEND, 32'h0000_0004);
        wr(IPST_OFS_CLR_PEND, 32'h0000_0004);
        rd(IPST_OFS_SET_PEND, 32'h0000_0004);
        far.line(2, 1'b0);
        repeat (6) @(posedge clk);
        wr(IPST_OFS_CLR_PEND, 32'h0000_0004);
        rd(IPST_OFS_SET_PEND, 32'h0000_0000);
        // Enable gates only the take output
        wr(IPST_OFS_ENABLE, 32'h0000_0010);
        rd(IPST_OFS_ENABLE, 32'h0000_0010);
        wr(IPST_OFS_SET_PEND, 32'h0000_0030);
        rd(IPST_OFS_SET_PEND, 32'h0000_0030);
        see(32'h0000_0010, irq_take);
        wr(IPST_OFS_CLR_PEND, 32'h0000_0030);
        rd(IPST_OFS_SET_PEND, 32'h0000_0000);
        see(32'h0000_0000, irq_take);
        // Priority bytes, whole word then one byte lane
        wr(IPST_OFS_PRIO_BASE, 32'hFFFF_FFFF);
        rd(IPST_OFS_PRIO_BASE, 32'hF0F0_F0F0);
        avs_byteenable <= 4'h2;
        wr(IPST_OFS_PRIO_BASE, 32'h0000_0000);
        avs_byteenable <= 4'hF;
        rd(IPST_OFS_PRIO_BASE, 32'hF0F0_00F0);
        rd(8'h40, IPST_UNMAPPED_RD);
        conclude();
    end
endmodule
